// ### hw/ssi_fast_feedback_word.sv
/*
 * Fast-mode feedback word of an absolute-encoder readout module.
 * Assumes a frame engine on CLK_SYS_IN delivering positions with a strobe,
 * and a controller delivering parameter sets with a strobe.
 */
// Summary of operation
// - Encoder position sits in bits 0 to 24 of the word.
// - Bit 31 is zero unless sign of life is on, then the toggle.
// - Bit 30 carries the ready flag, meaning the feedback is valid.
// - Bit 29 carries the parameter error flag.
// - Bit 28 carries the group fault flag for encoder and supply faults.
// - Bit 27 digital input, bit 26 direction down, bit 25 direction up.
// - Parameter error set when total steps fall outside the type's range.
// - Parameter error clears as soon as a valid parameter set arrives.
// - Group fault rises on encoder supply short circuit.
// - Group fault rises on faulty serial frames of any cause.
// - Group fault clears by itself once the short is gone and a clean frame has arrived.
// - Sign of life works only in isochronous mode.
// - Sign of life inverts on each encoder value read in.
// - With rate reduction, toggle only on cycles that really read a value.
// - Digital input status mirrors the module's digital input.
// - Direction down set on decreasing position, wrap through zero included.
// - Ready only with a correct parameter set while running.
`timescale 1ns/1ps
`include "fb_word_params.svh"

module ssi_fast_feedback_word
   import fb_word_pkg::*;
#(
   parameter int REDUCTION_W = 4
) (
   input  wire logic             CLK_SYS_IN,
   input  wire logic             RST_IN,
   input  wire param_set_t       PARAM_IN,
   input  wire logic             PARAM_LOAD_IN,
   input  wire logic             CYCLE_STROBE_IN,
   input  wire logic [24:0]      POS_IN,
   input  wire logic             POS_VALID_IN,
   input  wire logic             FRAME_ERR_IN,
   input  wire logic             SUPPLY_SHORT_IN,
   input  wire logic             DIG_IN,
   output logic                  READ_REQ_OUT,
   output feedback_word_t        FEEDBACK_OUT
);

   // ****************************************************************
   // Pin synchronisers
   // ****************************************************************
   logic [1:0] short_sync;
   logic [1:0] input_sync;

   // Two stages for each outside pin
   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         short_sync <= 2'h0;
         input_sync <= 2'h0;
      end else begin
         short_sync <= {short_sync[0], SUPPLY_SHORT_IN};
         input_sync <= {input_sync[0], DIG_IN};
      end
   end

   // ****************************************************************
   // Parameter check
   // ****************************************************************
   function automatic logic steps_ok(input param_set_t p);
      logic [25:0] max_steps;
      max_steps = p.multi_turn ? `STEPS_MAX_MULTI : `STEPS_MAX_SINGLE;
      steps_ok  = (p.total_steps >= `STEPS_MIN) && (p.total_steps <= max_steps);
   endfunction : steps_ok

   param_set_t  params;
   logic        param_err;
   run_state_t  state;
   param_set_t  next_params;
   logic        next_param_err;
   run_state_t  next_state;
   logic        load_ok;

   assign load_ok = PARAM_LOAD_IN && steps_ok(PARAM_IN);

   // Accept valid sets, flag bad ones
   always_comb begin
      next_params    = params;
      next_param_err = param_err;
      next_state     = state;
      if (PARAM_LOAD_IN) begin
         if (load_ok) begin
            next_params    = PARAM_IN;
            next_param_err = 1'b0;
            next_state     = ST_RUNNING;
         end else begin
            next_param_err = 1'b1;
            next_state     = ST_UNCONFIGURED;
         end
      end
      case (state)
         ST_UNCONFIGURED: ;
         ST_RUNNING:      ;
         default:         next_state = ST_UNCONFIGURED;
      endcase
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         params    <= '0;
         param_err <= 1'b0;
         state     <= ST_UNCONFIGURED;
      end else begin
         params    <= next_params;
         param_err <= next_param_err;
         state     <= next_state;
      end
   end

   // ****************************************************************
   // Sampling with rate reduction
   // ****************************************************************
   logic [REDUCTION_W-1:0] red_cnt;
   logic [REDUCTION_W-1:0] next_red_cnt;
   logic                   read_due;

   // Only every (reduction+1)-th cycle strobe reads the encoder
   assign read_due = CYCLE_STROBE_IN && (red_cnt == '0) && (state == ST_RUNNING);

   always_comb begin
      next_red_cnt = red_cnt;
      if (CYCLE_STROBE_IN && state == ST_RUNNING) begin
         if (red_cnt == '0) begin
            next_red_cnt = params.rate_reduction[REDUCTION_W-1:0];
         end else begin
            next_red_cnt = red_cnt - 1'b1;
         end
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         red_cnt <= '0;
      end else begin
         red_cnt <= next_red_cnt;
      end
   end

   assign READ_REQ_OUT = read_due;

   // ****************************************************************
   // Fault tracking
   // ****************************************************************
   logic frame_fault;
   logic next_frame_fault;

   // Frame fault holds until a clean frame arrives; set wins
   always_comb begin
      next_frame_fault = frame_fault;
      if (POS_VALID_IN && !FRAME_ERR_IN) begin
         next_frame_fault = 1'b0;
      end
      if (FRAME_ERR_IN) begin
         next_frame_fault = 1'b1;
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         frame_fault <= 1'b0;
      end else begin
         frame_fault <= next_frame_fault;
      end
   end

   // ****************************************************************
   // Position, direction and sign of life
   // ****************************************************************
   logic [24:0] pos;
   logic        dir_up;
   logic        dir_dn;
   logic        life;
   logic [24:0] next_pos;
   logic        next_dir_up;
   logic        next_dir_dn;
   logic        next_life;
   logic [24:0] delta;
   logic        good_value;
   logic        life_active;

   assign good_value  = POS_VALID_IN && !FRAME_ERR_IN;
   assign delta       = POS_IN - pos;
   assign life_active = params.life_enable && params.isochronous;

   // Modular difference catches wrap through zero both ways
   always_comb begin
      next_pos    = pos;
      next_dir_up = dir_up;
      next_dir_dn = dir_dn;
      next_life   = life;
      if (good_value) begin
         next_pos = POS_IN;
         if (delta != 25'h0) begin
            next_dir_dn = delta[24];
            next_dir_up = !delta[24];
         end
         if (life_active) begin
            next_life = !life;
         end
      end
      if (!life_active) begin
         next_life = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         pos    <= 25'h0;
         dir_up <= 1'b0;
         dir_dn <= 1'b0;
         life   <= 1'b0;
      end else begin
         pos    <= next_pos;
         dir_up <= next_dir_up;
         dir_dn <= next_dir_dn;
         life   <= next_life;
      end
   end

   // ****************************************************************
   // Feedback word assembly
   // ****************************************************************
   feedback_word_t next_word;

   // Word built from next-state values and the synchronised pins, registered to the output
   always_comb begin
      next_word                       = '0;
      next_word.position              = next_pos;
      next_word.sign_of_life_toggle   = life_active && next_life;
      next_word.ready                 = (next_state == ST_RUNNING)
                                        && !next_param_err;
      next_word.parameter_error_flag  = next_param_err;
      next_word.group_fault_flag      = short_sync[1]
                                        || next_frame_fault;
      next_word.digital_input_status  = input_sync[1];
      next_word.direction_down_status = next_dir_dn;
      next_word.direction_up_status   = next_dir_up;
   end

   always_ff @(posedge CLK_SYS_IN) begin
      if (RST_IN) begin
         FEEDBACK_OUT <= `FB_WORD_RESET;
      end else begin
         FEEDBACK_OUT <= next_word;
      end
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   chk_pos_follows: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (POS_VALID_IN && !FRAME_ERR_IN) |=> FEEDBACK_OUT[`FB_POS_MSB:`FB_POS_LSB] == $past(POS_IN))
      else $error("position not placed in word");

   chk_life_zero_off: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      !life_active |=> !FEEDBACK_OUT[`FB_BIT_LIFE])
      else $error("sign of life set while off");

   chk_bad_params: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (PARAM_LOAD_IN && !steps_ok(PARAM_IN))
      |=> FEEDBACK_OUT[`FB_BIT_PARAM_ERR] && !FEEDBACK_OUT[`FB_BIT_READY])
      else $error("bad step count not flagged");

   chk_good_params: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (PARAM_LOAD_IN && steps_ok(PARAM_IN))
      |=> !FEEDBACK_OUT[`FB_BIT_PARAM_ERR] && FEEDBACK_OUT[`FB_BIT_READY])
      else $error("valid parameters not accepted");

   chk_short_fault: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      SUPPLY_SHORT_IN [*3] |=> FEEDBACK_OUT[`FB_BIT_FAULT])
      else $error("supply short not reported");

   chk_frame_fault: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      FRAME_ERR_IN |=> FEEDBACK_OUT[`FB_BIT_FAULT])
      else $error("frame error not reported");

   chk_fault_clears: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (!SUPPLY_SHORT_IN [*3] ##0 (POS_VALID_IN && !FRAME_ERR_IN)) |=> !FEEDBACK_OUT[`FB_BIT_FAULT])
      else $error("group fault stuck after causes gone");

   chk_life_toggles: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (life_active && POS_VALID_IN && !FRAME_ERR_IN && !PARAM_LOAD_IN)
      |=> FEEDBACK_OUT[`FB_BIT_LIFE] != $past(FEEDBACK_OUT[`FB_BIT_LIFE]))
      else $error("sign of life did not toggle");

   chk_life_holds: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (life_active && !POS_VALID_IN && !PARAM_LOAD_IN) ##1 life_active
      |-> $stable(life))
      else $error("sign of life toggled without a read");

   chk_input_mirror: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      DIG_IN [*4] |-> FEEDBACK_OUT[`FB_BIT_DIG_IN])
      else $error("digital input status wrong");

   chk_dir_down: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (good_value && delta != 25'h0 && delta[24])
      |=> FEEDBACK_OUT[`FB_BIT_DN] && !FEEDBACK_OUT[`FB_BIT_UP])
      else $error("down direction not shown");

   chk_dir_up: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (good_value && delta != 25'h0 && !delta[24])
      |=> FEEDBACK_OUT[`FB_BIT_UP] && !FEEDBACK_OUT[`FB_BIT_DN])
      else $error("up direction not shown");

   chk_ready_valid: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      FEEDBACK_OUT[`FB_BIT_READY] |-> !FEEDBACK_OUT[`FB_BIT_PARAM_ERR] && state == ST_RUNNING)
      else $error("ready without valid parameters");

   chk_pos_holds: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      !(POS_VALID_IN && !FRAME_ERR_IN) |=> $stable(FEEDBACK_OUT[`FB_POS_MSB:`FB_POS_LSB]))
      else $error("position changed without a good frame");

   chk_life_iso_only: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      !params.isochronous |=> !FEEDBACK_OUT[`FB_BIT_LIFE])
      else $error("sign of life outside isochronous mode");

   chk_err_stable: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      !PARAM_LOAD_IN |=> $stable(FEEDBACK_OUT[`FB_BIT_PARAM_ERR]))
      else $error("parameter error changed without a load");

   chk_err_not_ready: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      FEEDBACK_OUT[`FB_BIT_PARAM_ERR] |-> !FEEDBACK_OUT[`FB_BIT_READY])
      else $error("ready while parameter error shown");

   chk_dir_exclusive: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      !(FEEDBACK_OUT[`FB_BIT_DN] && FEEDBACK_OUT[`FB_BIT_UP]))
      else $error("both directions shown");

   chk_input_low: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      !DIG_IN [*4] |-> !FEEDBACK_OUT[`FB_BIT_DIG_IN])
      else $error("digital input status stuck high");

   chk_read_on_strobe: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      READ_REQ_OUT |-> CYCLE_STROBE_IN)
      else $error("read request without cycle strobe");

   chk_idle_no_read: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (state != ST_RUNNING) |-> !READ_REQ_OUT)
      else $error("read request while unconfigured");

   chk_fault_none: assert property (@(posedge CLK_SYS_IN) disable iff (RST_IN)
      (!SUPPLY_SHORT_IN [*3] ##0 (!frame_fault && !FRAME_ERR_IN))
      |=> !FEEDBACK_OUT[`FB_BIT_FAULT])
      else $error("group fault without a cause");

endmodule : ssi_fast_feedback_word

// ### hw/fb_word_params.svh
/*
 * Constants of the fast-mode feedback word: field positions, reset values,
 * step-count limits per encoder type.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef FB_WORD_PARAMS_SVH
`define FB_WORD_PARAMS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define FB_WORD_OFFSET       32'h0000_0000
`define FB_WORD_RESET        32'h0000_0000

// ****************************************************************
// Field positions
// ****************************************************************
`define FB_POS_MSB           24
`define FB_POS_LSB           0
`define FB_BIT_UP            25
`define FB_BIT_DN            26
`define FB_BIT_DIG_IN        27
`define FB_BIT_FAULT         28
`define FB_BIT_PARAM_ERR     29
`define FB_BIT_READY         30
`define FB_BIT_LIFE          31

// ****************************************************************
// Permitted total step counts per encoder type
// ****************************************************************
`define STEPS_MIN            26'h000_0002
`define STEPS_MAX_SINGLE     26'h000_2000
`define STEPS_MAX_MULTI      26'h200_0000

`endif

// ### hw/fb_word_pkg.sv
/*
 * Types shared by the fast-mode feedback word block.
 * Assumes nothing of its surroundings.
 */
package fb_word_pkg;

   // ****************************************************************
   // Feedback word layout, bit 31 down to bit 0
   // ****************************************************************
   typedef struct packed {
      logic        sign_of_life_toggle;
      logic        ready;
      logic        parameter_error_flag;
      logic        group_fault_flag;
      logic        digital_input_status;
      logic        direction_down_status;
      logic        direction_up_status;
      logic [24:0] position;
   } feedback_word_t;

   // ****************************************************************
   // Parameter set as delivered by the controller
   // ****************************************************************
   typedef struct packed {
      logic        multi_turn;
      logic [25:0] total_steps;
      logic        life_enable;
      logic        isochronous;
      logic [3:0]  rate_reduction;
   } param_set_t;

   typedef enum logic [1:0] {
      ST_UNCONFIGURED,
      ST_RUNNING
   } run_state_t;

endpackage : fb_word_pkg

// ### verification/encoder_model.sv
/*
 * Behavioural absolute encoder with its frame engine, answering read requests.
 * Assumes requests and the bench's commands are sampled on the system clock.
 */
`timescale 1ns/1ps

module encoder_model #(
   parameter int LAT = 2
) (
   input  wire logic        clk_in,
   input  wire logic        read_req_in,
   input  wire logic [24:0] value_in,
   input  wire logic        fault_in,
   output logic [24:0]      pos_out,
   output logic             valid_out,
   output logic             err_out
);
   logic [LAT-1:0] pipe  = '0;
   logic [24:0]    last  = '0;

   // ************************************************************
   // Frame delay, then one good or faulty frame per request
   // ************************************************************
   // Data outside a frame shows the inverse of the last value
   always @(posedge clk_in) begin
      pipe      <= {pipe[LAT-2:0], read_req_in};
      valid_out <= pipe[LAT-1] & ~fault_in;
      err_out   <= pipe[LAT-1] & fault_in;
      if (pipe[LAT-1]) begin
         pos_out <= value_in;
         last    <= value_in;
      end else begin
         pos_out <= ~last;
      end
   end
endmodule : encoder_model

// ### verification/ssi_fast_feedback_word_test.sv
/*
 * Self-checking bench for the fast-mode feedback word, one task per scenario.
 * Assumes the encoder model answers each read request three cycles later.
 */
`timescale 1ns/1ps

module ssi_fast_feedback_word_test;
   import fb_word_pkg::*;
   logic           clk       = 1'b0;
   logic           rst       = 1'b1;
   param_set_t     prm       = '0;
   logic           prm_ld    = 1'b0;
   logic           strobe    = 1'b0;
   logic           dig       = 1'b0;
   logic           short_in  = 1'b0;
   logic           fault_cmd = 1'b0;
   logic [24:0]    value     = '0;
   logic [24:0]    pos;
   logic           pv;
   logic           fe;
   logic           req;
   feedback_word_t fb;
   int             miscompares = 0;
   int             n_tests     = 0;
   int             reqs        = 0;

   // ************************************************************
   // Clock, request counter, instances
   // ************************************************************
   always #4 clk = ~clk;

   always @(posedge clk) begin
      if (req) begin
         reqs <= reqs + 1;
      end
   end

   ssi_fast_feedback_word dut_u (
      .CLK_SYS_IN(clk), .RST_IN(rst), .PARAM_IN(prm), .PARAM_LOAD_IN(prm_ld),
      .CYCLE_STROBE_IN(strobe), .POS_IN(pos), .POS_VALID_IN(pv), .FRAME_ERR_IN(fe),
      .SUPPLY_SHORT_IN(short_in), .DIG_IN(dig), .READ_REQ_OUT(req), .FEEDBACK_OUT(fb));

   encoder_model enc_u (
      .clk_in(clk), .read_req_in(req), .value_in(value), .fault_in(fault_cmd),
      .pos_out(pos), .valid_out(pv), .err_out(fe));

   // ************************************************************
   // Shared tasks
   // ************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wait_cyc

   // Offer a parameter set, judge error and ready one cycle later
   task automatic load(input logic mt, input logic [25:0] st, input logic [1:0] li,
                       input logic [3:0] red, input logic err);
      @(posedge clk);
      prm    <= '{mt, st, li[1], li[0], red};
      prm_ld <= 1'b1;
      @(posedge clk);
      prm_ld <= 1'b0;
      #1;
      chk(fb.parameter_error_flag, err);
      chk(fb.ready, !err);
   endtask : load

   // One cycle strobe, then wait for the frame to land
   task automatic rd(input logic [24:0] v, input logic f);
      @(posedge clk);
      value     <= v;
      fault_cmd <= f;
      strobe    <= 1'b1;
      @(posedge clk);
      strobe <= 1'b0;
      wait_cyc(5);
   endtask : rd

   // Good read: position, directions {down, up} and life bit
   task automatic step(input logic [24:0] v, input logic [1:0] dir, input logic tog);
      logic l0;
      l0 = fb.sign_of_life_toggle;
      rd(v, 1'b0);
      chk(fb.position, v);
      chk({fb.direction_down_status, fb.direction_up_status}, dir);
      chk(fb.sign_of_life_toggle, tog ? !l0 : 1'b0);
   endtask : step

   // ************************************************************
   // Scenarios
   // ************************************************************
   task automatic t_reset();
      chk(fb, 32'h0000_0000);
      rd(25'h0000001, 1'b0);
      chk(reqs, 32'h0000_0000);
      chk(fb, 32'h0000_0000);
      $display("test reset finished");
   endtask : t_reset

   task automatic t_params();
      load(1'b0, 26'h0000001, 2'b11, 4'h0, 1'b1);
      load(1'b0, 26'h0000002, 2'b11, 4'h0, 1'b0);
      load(1'b0, 26'h0002001, 2'b11, 4'h0, 1'b1);
      load(1'b1, 26'h2000000, 2'b11, 4'h0, 1'b0);
      load(1'b1, 26'h2000001, 2'b11, 4'h0, 1'b1);
      load(1'b0, 26'h0002000, 2'b11, 4'h0, 1'b0);
      $display("test params finished");
   endtask : t_params

   task automatic t_position();
      step(25'h0000007, 2'b01, 1'b1);
      step(25'h0000005, 2'b10, 1'b1);
      step(25'h0000005, 2'b10, 1'b1);
      step(25'h1ffffff, 2'b10, 1'b1);
      step(25'h0000001, 2'b01, 1'b1);
      $display("test position finished");
   endtask : t_position

   task automatic t_fault();
      rd(25'h0000010, 1'b1);
      chk(fb.group_fault_flag, 1'b1);
      chk(fb.position, 25'h0000001);
      rd(25'h0000011, 1'b0);
      chk(fb.group_fault_flag, 1'b0);
      @(posedge clk);
      short_in <= 1'b1;
      dig      <= 1'b1;
      wait_cyc(4);
      chk(fb.group_fault_flag, 1'b1);
      chk(fb.digital_input_status, 1'b1);
      @(posedge clk);
      short_in <= 1'b0;
      dig      <= 1'b0;
      wait_cyc(4);
      chk(fb.group_fault_flag, 1'b0);
      chk(fb.digital_input_status, 1'b0);
      $display("test fault finished");
   endtask : t_fault

   task automatic t_life_modes();
      load(1'b0, 26'h0002000, 2'b10, 4'h0, 1'b0);
      step(25'h0000013, 2'b01, 1'b0);
      load(1'b0, 26'h0002000, 2'b01, 4'h0, 1'b0);
      step(25'h0000012, 2'b10, 1'b0);
      $display("test life modes finished");
   endtask : t_life_modes

   task automatic t_reduction();
      int   r0;
      logic l0;
      load(1'b0, 26'h0002000, 2'b11, 4'h2, 1'b0);
      r0 = reqs;
      l0 = fb.sign_of_life_toggle;
      for (int i = 0; i < 6; i++) begin
         rd(25'h0000100 + 25'(i), 1'b0);
      end
      chk(reqs - r0, 32'h0000_0002);
      chk(fb.sign_of_life_toggle, l0);
      $display("test reduction finished");
   endtask : t_reduction

   // ************************************************************
   // Verdict, main sequence, watchdog
   // ************************************************************
   task automatic finish_test();
      $display("comparisons %0d, mismatches %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   initial begin
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      wait_cyc(1);
      t_reset();
      t_params();
      t_position();
      t_fault();
      t_life_modes();
      t_reduction();
      finish_test();
   end

   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      finish_test();
   end
endmodule : ssi_fast_feedback_word_test
